// ---- design/acc_pkg.sv ----
package acc_pkg;
	// register map, 8-bit data, one register per address
	localparam logic [2:0] ACC_ADDR_CTRL = 3'h0;
	localparam logic [2:0] ACC_ADDR_INSEL = 3'h1;
	localparam logic [2:0] ACC_ADDR_CFG = 3'h2;
	localparam logic [2:0] ACC_ADDR_GAIN = 3'h3;
	localparam logic [2:0] ACC_ADDR_STAT = 3'h4;
	localparam logic [2:0] ACC_ADDR_RES_LO = 3'h5;
	localparam logic [2:0] ACC_ADDR_RES_HI = 3'h6;
	localparam logic [2:0] ACC_ADDR_TEST = 3'h7;
	// control register bit positions
	localparam int ACC_CTRL_START = 0;
	localparam int ACC_CTRL_DEF = 1;
	localparam int ACC_CTRL_CONT = 2;
	localparam int ACC_CTRL_MASK = 3;
	localparam int ACC_CTRL_REF = 4;
	// input selection field bit positions
	localparam int ACC_SEL_CROSS = 3;
	localparam int ACC_SEL_COMMON = 4;
	// configuration field positions
	localparam int ACC_CFG_OSR_LSB = 0;
	localparam int ACC_CFG_NEL_LSB = 4;
	// reset values
	localparam logic [4:0] ACC_INSEL_RESET = 5'h00;
	localparam logic ACC_REF_RESET = 1'b0;
	localparam logic [2:0] ACC_OSR_RESET = 3'h0;
	localparam logic [1:0] ACC_NEL_RESET = 2'h0;
	localparam logic [2:0] ACC_GAIN_RESET = 3'h0;
	// timing
	localparam int ACC_CLK_NS = 50;
	localparam int ACC_SAMPLE_NS = 2000;
	localparam int ACC_SAMPLE_CYC = ACC_SAMPLE_NS / ACC_CLK_NS;
	localparam int ACC_SETTLE_NS = 10000;
	localparam int ACC_SETTLE_CYC = (ACC_SETTLE_NS + ACC_CLK_NS - 1) / ACC_CLK_NS;
	localparam int ACC_NINIT = 5;
	localparam int ACC_NEND = 5;
	localparam int ACC_RES_W = 16;
	localparam int ACC_SMAX_BASE_LOG = 3;
	typedef enum logic [1:0] {ACC_IDLE, ACC_INIT, ACC_RUN, ACC_END} acc_state_t;
endpackage : acc_pkg

// ---- design/acc_input_decode.sv ----
`timescale 1ns/100ps
module acc_input_decode
	import acc_pkg::*;
(
	input wire logic [4:0] sel,
	output logic [2:0] pos_idx,
	output logic [2:0] neg_idx
);
	function automatic logic [5:0] acc_route(input logic [4:0] s);
		logic [2:0] p;
		logic [2:0] n;
		p = 3'h0;
		n = 3'h0;
		if (s[ACC_SEL_COMMON])
		begin
			p = s[2:0];
			n = 3'h0;
		end
		else
		begin
			p = {s[1:0], 1'b1};
			n = {s[1:0], 1'b0};
		end
		if (s[ACC_SEL_CROSS])
			return {n, p};
		return {p, n};
	endfunction : acc_route

	wire [5:0] route = acc_route(sel);
	assign pos_idx = route[5:3];
	assign neg_idx = route[2:0];
endmodule : acc_input_decode

// ---- design/acc_converter.sv ----
`timescale 1ns/100ps
module acc_converter
	import acc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic start,
	input wire logic tick,
	input wire logic mod_bit,
	input wire logic [2:0] osr,
	input wire logic [1:0] nelconv,
	output logic busy,
	output logic done,
	output logic cross_phase,
	output logic [15:0] result
);
	acc_state_t state;
	logic [10:0] sample_cnt;
	logic [2:0] conv_cnt;
	logic signed [16:0] acc;
	logic [2:0] osr_q;
	logic [1:0] nel_q;

	// smax = 8 * 2^osr, one elementary conversion takes smax+1 samples
	wire [10:0] smax = 11'(11'h008 << osr_q);
	wire [2:0] conv_last = 3'(3'h1 << nel_q) - 3'h1;
	wire sample_val = mod_bit ^ cross_phase;
	wire [3:0] shamt = 4'(15 - ACC_SMAX_BASE_LOG) - 4'(osr_q) - 4'(nel_q);
	wire signed [31:0] scaled = 32'(acc) <<< shamt;
	wire [15:0] saturated = (scaled > 32'sh00007FFF) ? 16'h7FFF :
		(scaled < -32'sh00008000) ? 16'h8000 : scaled[15:0];

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= ACC_IDLE;
			sample_cnt <= 11'h000;
			conv_cnt <= 3'h0;
			acc <= 17'sh00000;
			osr_q <= 3'h0;
			nel_q <= 2'h0;
			cross_phase <= 1'b0;
			done <= 1'b0;
			result <= 16'h0000;
		end
		else if (ce)
		begin
			done <= 1'b0;
			if (start)
			begin
				// any start, even mid-conversion, reopens the init phase
				state <= ACC_INIT;
				acc <= 17'sh00000;
				sample_cnt <= 11'h000;
				conv_cnt <= 3'h0;
				cross_phase <= 1'b0;
				osr_q <= osr;
				nel_q <= nelconv;
			end
			else if (tick)
			begin
				case (state)
					ACC_IDLE: ;
					ACC_INIT:
					begin
						sample_cnt <= sample_cnt + 11'h001;
						if (sample_cnt == 11'(ACC_NINIT - 1))
						begin
							sample_cnt <= 11'h000;
							state <= ACC_RUN;
						end
					end
					ACC_RUN:
					begin
						acc <= sample_val ? acc + 17'sh00001 : acc - 17'sh00001;
						sample_cnt <= sample_cnt + 11'h001;
						if (sample_cnt == smax)
						begin
							// alternate direct and crossed inputs to cancel offset
							sample_cnt <= 11'h000;
							cross_phase <= ~cross_phase;
							conv_cnt <= conv_cnt + 3'h1;
							if (conv_cnt == conv_last)
								state <= ACC_END;
						end
					end
					ACC_END:
					begin
						sample_cnt <= sample_cnt + 11'h001;
						if (sample_cnt == 11'(ACC_NEND - 1))
						begin
							sample_cnt <= 11'h000;
							cross_phase <= 1'b0;
							result <= saturated;
							done <= 1'b1;
							state <= ACC_IDLE;
						end
					end
					default: state <= ACC_IDLE;
				endcase
			end
		end
	end

	assign busy = (state != ACC_IDLE);
endmodule : acc_converter

// ---- design/acc_chain_ctrl.sv ----
`timescale 1ns/100ps
// Overview of operation
// - results are signed 16-bit two's-complement words
// - busy flag and maskable interrupt report conversion state
// - oversampling ratio programmable in powers of two only
// - accumulator cleared before every conversion starts
// - input change immediate with gains off, settling delay with gains on
// - on-request mode and continuous mode
// - polarity bit clear: bits 1:0 pick one of four adjacent pairs
// - bit 3 swaps positive and negative converter inputs
// - polarity bit set: input n against common input 0
// - after reset input 1 positive against input 0 negative
// - one of two reference pairs, first pair after reset
// - each of three gain stages bypassable on its own
// - control handles cpu access, configuration and test modes
// - setting start or default-conversion bit begins a conversion
// - continuous mode requests a new conversion at each finish
// - gain register write resets stages; start waits to settle
module acc_chain_ctrl
	import acc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [2:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rd_data,
	input wire logic mod_bit_pin,
	output logic [2:0] pos_input,
	output logic [2:0] neg_input,
	output logic ref_pair_sel,
	output logic [2:0] stage_enable,
	output logic stage_reset,
	output logic cross_inputs,
	output logic sample_strobe,
	output logic busy,
	output logic irq
);
	////////////////////////////////////////////////////////////////////////
	// registers
	logic [4:0] insel;
	logic ref_sel;
	logic cont_mode;
	logic irq_mask;
	logic [2:0] osr;
	logic [1:0] nelconv;
	logic [2:0] gain_en;
	logic [1:0] test_mode;
	logic [15:0] result_q;
	logic start_pending;
	logic [8:0] settle_cnt;
	logic [5:0] tick_cnt;
	logic mod_meta;
	logic mod_sync;
	logic conv_start;

	wire wr_ctrl = wr_en && (addr == ACC_ADDR_CTRL);
	wire wr_insel = wr_en && (addr == ACC_ADDR_INSEL);
	wire wr_cfg = wr_en && (addr == ACC_ADDR_CFG);
	wire wr_gain = wr_en && (addr == ACC_ADDR_GAIN);
	wire wr_test = wr_en && (addr == ACC_ADDR_TEST);
	wire sw_start = wr_ctrl && (wr_data[ACC_CTRL_START] || wr_data[ACC_CTRL_DEF]);
	wire conv_busy;
	wire conv_done;
	wire conv_cross;
	wire [15:0] conv_result;
	wire [2:0] dec_pos;
	wire [2:0] dec_neg;

	////////////////////////////////////////////////////////////////////////
	// settling and start sequencing
	wire gains_on = |gain_en;
	// with every stage bypassed a new input is used at once
	wire need_settle = wr_gain || (wr_insel && gains_on);
	wire settling = (settle_cnt != 9'h000);
	wire auto_start = conv_done && cont_mode;
	wire want_start = sw_start || auto_start || start_pending;
	wire next_conv_start = want_start && !need_settle && !settling;
	wire tick = (tick_cnt == 6'(ACC_SAMPLE_CYC - 1));
	// test mode 1 forces the modulator stream to test_mode[1]
	wire mod_bit = test_mode[0] ? test_mode[1] : mod_sync;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			settle_cnt <= 9'h000;
			start_pending <= 1'b0;
			conv_start <= 1'b0;
			tick_cnt <= 6'h00;
			mod_meta <= 1'b0;
			mod_sync <= 1'b0;
		end
		else if (ce)
		begin
			mod_meta <= mod_bit_pin;
			mod_sync <= mod_meta;
			tick_cnt <= tick ? 6'h00 : tick_cnt + 6'h01;
			if (need_settle)
				settle_cnt <= 9'(ACC_SETTLE_CYC);
			else if (settling)
				settle_cnt <= settle_cnt - 9'h001;
			// a start held during settling is issued once settling ends
			start_pending <= want_start && !next_conv_start;
			conv_start <= next_conv_start;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// software registers
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			insel <= ACC_INSEL_RESET;
			ref_sel <= ACC_REF_RESET;
			cont_mode <= 1'b0;
			irq_mask <= 1'b0;
			osr <= ACC_OSR_RESET;
			nelconv <= ACC_NEL_RESET;
			gain_en <= ACC_GAIN_RESET;
			test_mode <= 2'h0;
		end
		else if (ce)
		begin
			if (wr_ctrl)
			begin
				cont_mode <= wr_data[ACC_CTRL_CONT];
				irq_mask <= wr_data[ACC_CTRL_MASK];
				ref_sel <= wr_data[ACC_CTRL_REF];
			end
			if (wr_insel)
				insel <= wr_data[4:0];
			if (wr_cfg)
			begin
				osr <= wr_data[ACC_CFG_OSR_LSB +: 3];
				nelconv <= wr_data[ACC_CFG_NEL_LSB +: 2];
			end
			if (wr_gain)
				gain_en <= wr_data[2:0];
			if (wr_test)
				test_mode <= wr_data[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs to the analog chain and the cpu
	wire [7:0] stat_word = {5'h00, settling, start_pending, conv_busy};
	wire [7:0] ctrl_word = {3'h0, ref_sel, irq_mask, cont_mode, 2'h0};
	wire [7:0] read_mux =
		(addr == ACC_ADDR_CTRL) ? ctrl_word :
		(addr == ACC_ADDR_INSEL) ? {3'h0, insel} :
		(addr == ACC_ADDR_CFG) ? {2'h0, nelconv, 1'b0, osr} :
		(addr == ACC_ADDR_GAIN) ? {5'h00, gain_en} :
		(addr == ACC_ADDR_STAT) ? stat_word :
		(addr == ACC_ADDR_RES_LO) ? result_q[7:0] :
		(addr == ACC_ADDR_RES_HI) ? result_q[15:8] : {6'h00, test_mode};

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_data <= 8'h00;
			result_q <= 16'h0000;
			pos_input <= 3'h1;
			neg_input <= 3'h0;
			ref_pair_sel <= ACC_REF_RESET;
			stage_enable <= ACC_GAIN_RESET;
			stage_reset <= 1'b0;
			cross_inputs <= 1'b0;
			sample_strobe <= 1'b0;
			busy <= 1'b0;
			irq <= 1'b0;
		end
		else if (ce)
		begin
			rd_data <= rd_en ? read_mux : 8'h00;
			if (conv_done)
				result_q <= conv_result;
			pos_input <= dec_pos;
			neg_input <= dec_neg;
			ref_pair_sel <= ref_sel;
			stage_enable <= gain_en;
			stage_reset <= wr_gain;
			cross_inputs <= conv_cross;
			sample_strobe <= tick;
			busy <= next_conv_start || conv_start || (conv_busy && !conv_done);
			irq <= conv_done && !irq_mask;
		end
	end

	acc_input_decode u_decode (
		.sel(insel),
		.pos_idx(dec_pos),
		.neg_idx(dec_neg)
	);

	acc_converter u_conv (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.ce(ce),
		.start(conv_start),
		.tick(tick),
		.mod_bit(mod_bit),
		.osr(osr),
		.nelconv(nelconv),
		.busy(conv_busy),
		.done(conv_done),
		.cross_phase(conv_cross),
		.result(conv_result)
	);
endmodule : acc_chain_ctrl

// ---- dv/acc_chain_ctrl_asserts.sv ----
`timescale 1ns/100ps
module acc_chain_ctrl_asserts
	import acc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [2:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] rd_data,
	input wire logic [2:0] pos_input,
	input wire logic [2:0] neg_input,
	input wire logic ref_pair_sel,
	input wire logic [2:0] stage_enable,
	input wire logic stage_reset,
	input wire logic sample_strobe,
	input wire logic busy,
	input wire logic irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	logic msk;
	wire gw = wr_en && addr == ACC_ADDR_GAIN;
	wire cw = wr_en && addr == ACC_ADDR_CTRL;
	// shadow of the interrupt mask bit
	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			msk <= 1'b0;
		else if (cw)
			msk <= wr_data[ACC_CTRL_MASK];
	a_rd_quiet: assert property (!$past(rd_en) |-> rd_data == 8'h00)
		else $error("read data outside read slot");
	a_stage_rst: assert property (gw |=> stage_reset)
		else $error("no stage reset after gain write");
	a_stage_cause: assert property (stage_reset |-> $past(gw))
		else $error("stage reset without gain write");
	a_gain_bypass: assert property (gw |-> ##2 stage_enable == $past(wr_data[2:0], 2))
		else $error("stage enables differ from write");
	a_ref_pick: assert property (cw |-> ##2 ref_pair_sel == $past(wr_data[ACC_CTRL_REF], 2))
		else $error("reference pair differs from write");
	a_irq_pulse: assert property (irq |=> !irq)
		else $error("irq longer than one cycle");
	a_irq_busy: assert property (irq |-> $past(busy) && !$past(msk))
		else $error("irq while masked or idle");
	a_strobe_gap: assert property (sample_strobe |=> !sample_strobe [*8])
		else $error("sample strobes too close");
	a_common_short: assert property (pos_input == neg_input |-> pos_input == 3'h0)
		else $error("equal inputs other than input 0");
endmodule : acc_chain_ctrl_asserts
bind acc_chain_ctrl acc_chain_ctrl_asserts u_acc_chain_ctrl_asserts (.sys_clk, .rst_n, .addr, .wr_data,
	.wr_en, .rd_en, .rd_data, .pos_input, .neg_input, .ref_pair_sel, .stage_enable, .stage_reset,
	.sample_strobe, .busy, .irq);

// ---- dv/acc_sensor_model.sv ----
`timescale 1ns/100ps
module acc_sensor_model
(
	input wire logic sys_clk,
	input wire logic positive,
	output logic mod_bit
);
	// modulator driven by a sensor at positive or negative full scale
	always_ff @(posedge sys_clk)
		mod_bit <= positive;
endmodule : acc_sensor_model

// ---- dv/tb_acquisition_chain_control.sv ----
`timescale 1ns/100ps
module tb_acquisition_chain_control
	import acc_pkg::*;
;
	logic sys_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, wr_en = 1'b0, rd_en = 1'b0, up = 1'b1;
	logic [2:0] addr = 3'h0, pos_input, neg_input, stage_enable;
	logic [7:0] wr_data = 8'h00, rd_data;
	logic mod_bit, ref_pair_sel, stage_reset, cross_inputs, sample_strobe, busy, irq;
	int error_cnt = 0, n_compared = 0;
	always #25 sys_clk = ~sys_clk;
	acc_sensor_model u_acc_sensor_model (.sys_clk, .positive(up), .mod_bit);
	acc_chain_ctrl u_acc_chain_ctrl (.sys_clk, .rst_n, .ce, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
		.mod_bit_pin(mod_bit), .pos_input, .neg_input, .ref_pair_sel, .stage_enable, .stage_reset,
		.cross_inputs, .sample_strobe, .busy, .irq);
	////////////////////////////////////////
	task automatic summarize;
		$display("errors %0d compared %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge sys_clk);
		wr_en <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		@(negedge sys_clk);
		d = rd_data;
	endtask : rd
	task automatic wait_irq(output int n);
		n = 0;
		do
			@(negedge sys_clk);
		while (irq !== 1'b1 && ++n < 3000);
	endtask : wait_irq
	////////////////////////////////////////
	task automatic t_mux;
		logic [2:0] p, n;
		for (int i = 0; i < 32; i++)
		begin
			wr(ACC_ADDR_INSEL, 8'(i));
			repeat (3) @(negedge sys_clk);
			p = i[4] ? i[2:0] : {i[1:0], 1'b1};
			n = i[4] ? 3'h0 : {i[1:0], 1'b0};
			cmp({pos_input, neg_input}, i[3] ? {n, p} : {p, n});
		end
		wr(ACC_ADDR_INSEL, 8'h00);
	endtask : t_mux
	task automatic t_conv(input int osr, input int nel, input logic lvl, input logic [15:0] exp);
		int n;
		int t = ACC_NINIT + (((8 << osr) + 1) << nel) + ACC_NEND;
		logic [7:0] lo, hi;
		up <= lvl;
		wr(ACC_ADDR_CFG, 8'((nel << ACC_CFG_NEL_LSB) | osr));
		wr(ACC_ADDR_CTRL, 8'h01);
		repeat (2) @(negedge sys_clk);
		cmp(busy, 1'b1);
		cmp(cross_inputs, 1'b0);
		wait_irq(n);
		cmp(n / ACC_SAMPLE_CYC inside {[t - 1:t + 1]}, 1'b1);
		rd(ACC_ADDR_RES_LO, lo);
		rd(ACC_ADDR_RES_HI, hi);
		cmp({hi, lo}, exp);
	endtask : t_conv
	task automatic t_mask;
		int n;
		logic seen;
		seen = 1'b0;
		wr(ACC_ADDR_CTRL, 8'h09);
		repeat (2) @(negedge sys_clk);
		for (n = 0; busy === 1'b1 && n < 3000; n++)
		begin
			@(negedge sys_clk);
			seen |= irq;
		end
		cmp({seen, busy}, 2'b00);
	endtask : t_mask
	task automatic t_start;
		int n;
		wr(ACC_ADDR_CTRL, 8'h02);
		repeat (2) @(negedge sys_clk);
		cmp(busy, 1'b1);
		repeat (200) @(negedge sys_clk);
		wr(ACC_ADDR_CTRL, 8'h01);
		wait_irq(n);
		cmp(n > 17 * ACC_SAMPLE_CYC, 1'b1);
	endtask : t_start
	task automatic t_cont;
		int n;
		wr(ACC_ADDR_CTRL, 8'h05);
		wait_irq(n);
		wait_irq(n);
		cmp(n / ACC_SAMPLE_CYC inside {[18:20]}, 1'b1);
		wr(ACC_ADDR_CTRL, 8'h00);
		wait_irq(n);
		repeat (3) @(negedge sys_clk);
		cmp(busy, 1'b0);
	endtask : t_cont
	task automatic t_gain;
		int n;
		logic [7:0] s;
		wr(ACC_ADDR_GAIN, 8'h05);
		wr(ACC_ADDR_CTRL, 8'h01);
		rd(ACC_ADDR_STAT, s);
		cmp({stage_enable, s[2:0], busy}, 7'h5C);
		for (n = 0; busy !== 1'b1 && n < 400; n++)
			@(negedge sys_clk);
		cmp(n inside {[ACC_SETTLE_CYC - 12:ACC_SETTLE_CYC]}, 1'b1);
		wait_irq(n);
		wr(ACC_ADDR_GAIN, 8'h00);
		repeat (ACC_SETTLE_CYC + 10) @(negedge sys_clk);
	endtask : t_gain
	////////////////////////////////////////
	initial
	begin
		logic [7:0] s;
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(negedge sys_clk);
		cmp({pos_input, neg_input}, 6'h08);
		cmp({ref_pair_sel, stage_enable, busy, irq}, 6'h00);
		t_mux();
		wr(ACC_ADDR_CTRL, 8'h10);
		rd(ACC_ADDR_CTRL, s);
		cmp({ref_pair_sel, s}, 9'h110);
		t_conv(0, 0, 1'b1, 16'h7FFF);
		t_conv(1, 0, 1'b0, 16'h8000);
		t_conv(0, 1, 1'b1, 16'h0000);
		wr(ACC_ADDR_TEST, 8'h01);
		t_conv(0, 0, 1'b1, 16'h8000);
		wr(ACC_ADDR_TEST, 8'h00);
		t_mask();
		t_start();
		t_cont();
		t_gain();
		summarize();
	end
	// watchdog well beyond the expected run of about 9000 cycles
	initial
	begin
		#1000000;
		error_cnt++;
		summarize();
	end
endmodule : tb_acquisition_chain_control
